// file: pkg/dpm_consts.svh
// Purpose: Constants of the debug pin mode selector.
// Assumes: AXI4-Lite slave, 32-bit data, byte addresses.
// Notes: Offsets are byte addresses.
`ifndef DPM_CONSTS_SVH
`define DPM_CONSTS_SVH
`define DPM_SDRAM_CTL_OFF 12'h010
`define DPM_STRAP_STAT_OFF 12'h014
`define DPM_CTL_WIDTH 8
`define DPM_CTL_RESET 8'h01
`define DPM_DBG_EN_BIT 0
`define DPM_WBUF_SEL_BIT 4
`define DPM_RESP_OKAY 2'h0
`define DPM_RESP_DECERR 2'h3
`endif

// file: pkg/dpm_pkg.sv
// Purpose: Types of the debug pin mode selector.
// Assumes: Included constants header.
// Notes: Pin order is bit 2 to bit 0.
package dpm_pkg;
    typedef struct packed {
        logic dramCodeFetchFlag;
        logic sdramDataValidStrobe;
        logic romBusCodeFetchFlag;
    } dpm_trace_t;
    typedef struct packed {
        logic [2:0] pinOut;
        logic [2:0] pinOe;
    } dpm_pin_drive_t;
endpackage : dpm_pkg

// file: rtl/debug_pin_mode_mux.sv
// Purpose: Selects the function of three shared debug pins, with an AXI4-Lite register slave.
// Assumes: All inputs synchronous to clk; trace inputs come from the SDRAM and ROM controllers.
// Notes: Pin drive is registered, so pin outputs trail their sources by one clock.
// Notes: With debug disabled the pins go back to their other function.
`timescale 1ns/1ps
`include "dpm_consts.svh"
module debug_pin_mode_mux (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // AXI4-Lite write address and data
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Trace sources and write buffer master
    input wire dpm_pkg::dpm_trace_t traceIn,
    input wire logic [2:0] writeBufferMasterField,
    // Other function sharing the pins
    input wire logic [2:0] otherOut,
    input wire logic [2:0] otherOe,
    // Shared pins and power-good
    input wire logic [2:0] pinIn,
    output dpm_pkg::dpm_pin_drive_t pinDrive,
    input wire logic powerGoodInput,
    output logic [2:0] configStraps
);
    import dpm_pkg::*;

    logic [`DPM_CTL_WIDTH-1:0] ctl_reg;
    logic [11:0] awAddr_reg;
    logic awHeld_reg;
    logic [31:0] wData_reg;
    logic [3:0] wStrb_reg;
    logic wHeld_reg;
    logic bValid_reg;
    logic [1:0] bResp_reg;
    logic rValid_reg;
    logic [31:0] rData_reg;
    logic [1:0] rResp_reg;
    logic powerGoodPrev_reg;
    logic [2:0] straps_reg;
    dpm_pin_drive_t drive_reg;
    dpm_pin_drive_t drive_next;
    logic doWrite;
    logic powerGoodRise;

    function automatic logic isMapped(input logic [11:0] addr);
        isMapped = (addr == `DPM_SDRAM_CTL_OFF) || (addr == `DPM_STRAP_STAT_OFF);
    endfunction : isMapped

    // Byte lanes below a word are ignored
    function automatic logic [11:0] wordAddr(input logic [11:0] addr);
        wordAddr = {addr[11:2], 2'h0};
    endfunction : wordAddr

    function automatic logic [1:0] respFor(input logic [11:0] addr);
        respFor = isMapped(addr) ? `DPM_RESP_OKAY : `DPM_RESP_DECERR;
    endfunction : respFor

    // Unmapped words read as zero so software never sees stale data
    function automatic logic [31:0] readWord(input logic [11:0] addr,
                                             input logic [`DPM_CTL_WIDTH-1:0] ctl,
                                             input logic [2:0] straps);
        if (addr == `DPM_SDRAM_CTL_OFF) begin
            readWord = {24'h00_0000, ctl};
        end else if (addr == `DPM_STRAP_STAT_OFF) begin
            readWord = {29'h0000_0000, straps};
        end else begin
            readWord = 32'h0000_0000;
        end
    endfunction : readWord

    // bvalid blocks both channels so a new write cannot overtake the response
    assign s_axi_awready = !awHeld_reg && !bValid_reg;
    assign s_axi_wready = !wHeld_reg && !bValid_reg;
    // Write lands once both halves are held
    assign doWrite = awHeld_reg && wHeld_reg && !bValid_reg;

    always_ff @(posedge clk) begin
        if (srst) begin
            awHeld_reg <= 1'b0;
            awAddr_reg <= 12'h000;
        end else if (s_axi_awvalid && s_axi_awready) begin
            awHeld_reg <= 1'b1;
            awAddr_reg <= wordAddr(s_axi_awaddr);
        end else if (doWrite) begin
            awHeld_reg <= 1'b0;
        end
    end

    // Data may arrive before or after its address
    always_ff @(posedge clk) begin
        if (srst) begin
            wHeld_reg <= 1'b0;
            wData_reg <= 32'h0000_0000;
            wStrb_reg <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            wHeld_reg <= 1'b1;
            wData_reg <= s_axi_wdata;
            wStrb_reg <= s_axi_wstrb;
        end else if (doWrite) begin
            wHeld_reg <= 1'b0;
        end
    end

    // Only lane 0 holds bits; strap status is read-only
    always_ff @(posedge clk) begin
        if (srst) begin
            ctl_reg <= `DPM_CTL_RESET;
        end else if (doWrite && awAddr_reg == `DPM_SDRAM_CTL_OFF && wStrb_reg[0]) begin
            ctl_reg <= wData_reg[`DPM_CTL_WIDTH-1:0];
        end
    end

    // Response stands until bready; no new write is taken meanwhile
    always_ff @(posedge clk) begin
        if (srst) begin
            bValid_reg <= 1'b0;
            bResp_reg <= `DPM_RESP_OKAY;
        end else if (doWrite) begin
            bValid_reg <= 1'b1;
            bResp_reg <= respFor(awAddr_reg);
        end else if (s_axi_bready) begin
            bValid_reg <= 1'b0;
        end
    end

    assign s_axi_arready = !rValid_reg;

    // One read in flight; arready reopens as the answer is taken
    always_ff @(posedge clk) begin
        if (srst) begin
            rValid_reg <= 1'b0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rValid_reg <= 1'b1;
        end else if (s_axi_rready) begin
            rValid_reg <= 1'b0;
        end
    end

    // Word taken with the address and held until rready
    always_ff @(posedge clk) begin
        if (srst) begin
            rData_reg <= 32'h0000_0000;
            rResp_reg <= `DPM_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rData_reg <= readWord(wordAddr(s_axi_araddr), ctl_reg, straps_reg);
            rResp_reg <= respFor(wordAddr(s_axi_araddr));
        end
    end

    assign s_axi_bvalid = bValid_reg;
    assign s_axi_bresp = bResp_reg;
    assign s_axi_rvalid = rValid_reg;
    assign s_axi_rdata = rData_reg;
    assign s_axi_rresp = rResp_reg;

    // Straps taken on the power-good rising edge only, never from pin traffic later
    always_ff @(posedge clk) begin
        if (srst) begin
            powerGoodPrev_reg <= 1'b0;
        end else begin
            powerGoodPrev_reg <= powerGoodInput;
        end
    end

    assign powerGoodRise = powerGoodInput && !powerGoodPrev_reg;

    always_ff @(posedge clk) begin
        if (srst) begin
            straps_reg <= 3'h0;
        end else if (powerGoodRise) begin
            straps_reg <= pinIn;
        end
    end

    assign configStraps = straps_reg;

    // Debug use wins by forcing every enable
    always_comb begin
        drive_next.pinOut = otherOut;
        drive_next.pinOe = otherOe;
        if (ctl_reg[`DPM_DBG_EN_BIT]) begin
            drive_next.pinOe = 3'h7;
            if (ctl_reg[`DPM_WBUF_SEL_BIT]) begin
                drive_next.pinOut = writeBufferMasterField;
            end else begin
                // Strobe passed as given; source asserts it only for latchable data
                drive_next.pinOut = {traceIn.dramCodeFetchFlag,
                                     traceIn.sdramDataValidStrobe,
                                     traceIn.romBusCodeFetchFlag};
            end
        end
    end

    // Registered so a mode change cannot glitch the pins
    always_ff @(posedge clk) begin
        if (srst) begin
            drive_reg <= '0;
        end else begin
            drive_reg <= drive_next;
        end
    end

    assign pinDrive = drive_reg;
endmodule : debug_pin_mode_mux

// file: test/dpm_mux_props.sv
// Purpose: Port checks of the pin selector
// Assumes: Mode bit is internal
// Notes: Mode itself is checked by the bench
`timescale 1ns/1ps
module dpm_mux_props (
    // Watched ports
    input wire logic clk,
    input wire logic srst,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire dpm_pkg::dpm_trace_t traceIn,
    input wire logic [2:0] writeBufferMasterField,
    input wire logic [2:0] otherOut,
    input wire logic [2:0] otherOe,
    input wire logic [2:0] pinIn,
    input wire dpm_pkg::dpm_pin_drive_t pinDrive,
    input wire logic powerGoodInput,
    input wire logic [2:0] configStraps
);
    import dpm_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    AST_RST_OE: assert property ($fell(srst) |=> pinDrive.pinOe == 3'h7)
        else $error("pins not driven");
    AST_RST_OUT: assert property ($fell(srst) |=> pinDrive.pinOut == $past(traceIn))
        else $error("no trace after reset");
    AST_OTHER: assert property (!$past(srst) && pinDrive.pinOe != 3'h7
        |-> pinDrive == {$past(otherOut), $past(otherOe)}) else $error("other use lost");
    AST_SOURCE: assert property (pinDrive.pinOe == 3'h7 && $past(otherOe) != 3'h7
        && !$past(srst)
        |-> pinDrive.pinOut == $past(traceIn) || pinDrive.pinOut == $past(writeBufferMasterField))
        else $error("pin source wrong");
    AST_STRAP_HOLD: assert property ($changed(configStraps) |-> $past(powerGoodInput)
        && !$past(powerGoodInput, 2)) else $error("straps moved");
    AST_STRAP_LOAD: assert property ($rose(powerGoodInput) |=> configStraps == $past(pinIn))
        else $error("straps not taken");
    AST_READ: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("no read answer");
    AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("ar open");
    cover property ($rose(powerGoodInput));
    cover property (pinDrive.pinOe == 3'h1);
    cover property (s_axi_rvalid);
endmodule : dpm_mux_props
bind debug_pin_mode_mux dpm_mux_props u_props (.clk(clk), .srst(srst),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
    .traceIn(traceIn), .writeBufferMasterField(writeBufferMasterField), .otherOut(otherOut),
    .otherOe(otherOe), .pinIn(pinIn), .pinDrive(pinDrive), .powerGoodInput(powerGoodInput),
    .configStraps(configStraps));

// file: test/dpm_analyzer.sv
// Purpose: Analyzer and strap pulls on the pins
// Assumes: Pulls win only where nobody drives
// Notes: Counts strobe-qualified captures
`timescale 1ns/1ps
module dpm_analyzer (
    // Pins and board pulls
    input wire logic clk,
    input wire dpm_pkg::dpm_pin_drive_t pinDrive,
    input wire logic [2:0] strapPull,
    output logic [2:0] pinIn,
    output int captures
);
    import dpm_pkg::*;
    int count = 0;
    assign pinIn = (pinDrive.pinOut & pinDrive.pinOe) | (strapPull & ~pinDrive.pinOe);
    assign captures = count;
    // Capture only while the strobe pin is driven high
    always @(posedge clk) begin
        if (pinDrive.pinOe[1] && pinDrive.pinOut[1]) begin
            count <= count + 1;
        end
    end
endmodule : dpm_analyzer

// file: test/debug_pin_mode_mux_test.sv
// Purpose: Bench of the debug pin selector
// Assumes: Bus answers well inside the watchdog span
// Notes: Strap levels come from board pulls on pins 2 and 1; pin 0 is driven by otherOut
`timescale 1ns/1ps
module debug_pin_mode_mux_test;
    import dpm_pkg::*;
    logic clk = 0, srst = 1, powerGoodInput = 0, s_axi_bready = 0, s_axi_rready = 0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata;
    logic [2:0] writeBufferMasterField = 3'h6, otherOut = 0, otherOe = 0, pull = 3'h5;
    logic [2:0] pinIn, configStraps;
    dpm_trace_t traceIn = 3'h5;
    dpm_pin_drive_t pinDrive;
    int captures, failures = 0, num_checks = 0;
    debug_pin_mode_mux dut (.*);
    dpm_analyzer far (.clk, .pinDrive, .strapPull(pull), .pinIn, .captures);
    initial forever #12.5 clk = ~clk;
    initial begin
        #100000;
        failures++;
        conclude();
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic pin(input logic [5:0] exp);
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk({26'h0, pinDrive}, {26'h0, exp});
    endtask : pin
    // Write if w, else read; each valid is held until its own ready
    task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [1:0] r);
        logic done;
        done = 0;
        @(posedge clk);
        if (w) begin
            s_axi_awaddr <= a;
            s_axi_wdata <= d;
            s_axi_awvalid <= 1;
            s_axi_wvalid <= 1;
            s_axi_bready <= 1;
        end else begin
            s_axi_araddr <= a;
            s_axi_arvalid <= 1;
            s_axi_rready <= 1;
        end
        while (!done) begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
            if (s_axi_arready) s_axi_arvalid <= 0;
            if (w ? s_axi_bvalid : s_axi_rvalid) begin
                done = 1;
                s_axi_bready <= 0;
                s_axi_rready <= 0;
                chk({30'h0, w ? s_axi_bresp : s_axi_rresp}, {30'h0, r});
                if (!w) chk(s_axi_rdata, d);
            end
        end
    endtask : acc
    task automatic conclude();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : conclude
    initial begin
        repeat (2) @(posedge clk);
        srst <= 0;
        pin({3'h5, 3'h7});
        acc(0, 12'h010, 32'h1, 2'h0);
        $display("reset test done");
        @(posedge clk);
        traceIn <= 3'h2;
        pin({3'h2, 3'h7});
        chk(captures, 32'h1);
        acc(1, 12'h010, 32'h11, 2'h0);
        pin({3'h6, 3'h7});
        acc(0, 12'h010, 32'h11, 2'h0);
        $display("mode test done");
        otherOut <= 3'h3;
        otherOe <= 3'h1;
        acc(1, 12'h010, 32'h10, 2'h0);
        pin({3'h3, 3'h1});
        acc(1, 12'h010, 32'h1, 2'h0);
        pin({3'h2, 3'h7});
        $display("override test done");
        acc(1, 12'h010, 32'h0, 2'h0);
        powerGoodInput <= 1;
        acc(0, 12'h014, 32'h5, 2'h0);
        pull <= 3'h2;
        acc(0, 12'h014, 32'h5, 2'h0);
        chk({29'h0, configStraps}, 32'h5);
        acc(0, 12'h020, 32'h0, 2'h3);
        acc(1, 12'h020, 32'h0, 2'h3);
        acc(0, 12'h010, 32'h0, 2'h0);
        $display("strap test done");
        conclude();
    end
endmodule : debug_pin_mode_mux_test
